/* File: acd_dispatch.sv */
`timescale 1ns/1ps
module acd_dispatch
	import acd_pkg::*;
#(
	parameter int CYCLES_PER_MS = ACD_CYCLES_PER_MS
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Link layer: wake token and input bytes
	input wire logic wake_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	output logic rx_ready_o,
	// Link layer: output block read-back
	input wire logic tx_rd_i,
	output logic tx_avail_o,
	output logic [7:0] tx_data_o,
	output logic busy_o,
	// Shared-bus pause selector
	input wire logic [3:0] pause_sel_i,
	output logic pause_idle_o,
	// Command engine: start and held command
	output logic exec_start_o,
	output logic exec_abort_o,
	output logic [7:0] exec_opcode_o,
	output logic [7:0] exec_param1_o,
	output logic [15:0] exec_param2_o,
	output logic [6:0] exec_count_o,
	input wire logic [6:0] cmd_addr_i,
	output logic [7:0] cmd_byte_o,
	// Command engine: result bytes and completion
	input wire logic res_valid_i,
	input wire logic [7:0] res_data_i,
	input wire logic exec_done_i,
	input wire logic [7:0] exec_status_i
);

	acd_state_t state_reg;
	logic [7:0] ibuf [0:83];
	logic [7:0] obuf [0:83];
	logic [6:0] rx_idx_reg;
	logic [6:0] rx_cnt_reg;
	logic [15:0] rx_crc_reg;
	logic [7:0] rx_lsb_reg;
	logic [6:0] pkt_len_reg;
	logic [6:0] res_cnt_reg;
	logic [6:0] seal_idx_reg;
	logic [15:0] seal_crc_reg;
	logic [6:0] out_len_reg;
	logic [6:0] out_ptr_reg;
	logic [6:0] out_ptr_next;
	logic [7:0] tx_data_reg;
	logic [31:0] exec_cnt_reg;
	logic [31:0] exec_limit_reg;
	logic exec_start_reg;
	logic exec_abort_reg;
	logic pause_idle_reg;

	logic rx_take;
	logic rx_first;
	logic rx_last;
	logic [15:0] rx_crc_in;
	logic [15:0] rx_crc_next;
	logic [7:0] seal_byte;
	logic [15:0] seal_crc_next;
	logic [6:0] blk_len;
	logic dec_known;
	logic [6:0] dec_len_min;
	logic [6:0] dec_len_max;
	logic [6:0] dec_max_ms;
	logic count_bad;
	logic crc_ok;
	logic parse_bad;
	logic is_pause;
	logic pause_hit;
	logic exec_timeout;
	logic post_vld;
	logic post_res;
	logic [7:0] post_code;
	logic go_exec;

	// Input checksum, fed from the link byte
	acd_crc16 u_rx_crc (
		.crc_i(rx_crc_in),
		.data_i(rx_data_i),
		.crc_o(rx_crc_next)
	);

	// Output checksum, walked over the packed block
	acd_crc16 u_tx_crc (
		.crc_i(seal_crc_reg),
		.data_i(seal_byte),
		.crc_o(seal_crc_next)
	);

	// Opcode table on the held opcode byte
	acd_opdec u_opdec (
		.opcode_i(ibuf[ACD_IDX_OPCODE]),
		.known_o(dec_known),
		.len_min_o(dec_len_min),
		.len_max_o(dec_len_max),
		.max_ms_o(dec_max_ms)
	);

	// Link is only listened to outside a running command
	assign rx_ready_o = (state_reg == ACD_IDLE) || (state_reg == ACD_RECV);
	assign busy_o = (state_reg == ACD_EXEC) || (state_reg == ACD_SEAL);
	assign rx_take = rx_valid_i && rx_ready_o;
	assign rx_first = rx_take && (state_reg == ACD_IDLE);
	assign rx_last = rx_take && (state_reg == ACD_RECV) && (rx_idx_reg == rx_cnt_reg - 7'd1);
	assign rx_crc_in = (state_reg == ACD_IDLE) ? ACD_CRC_INIT : rx_crc_reg;

	// Out-of-range count cannot be framed; treated as a link fault
	assign count_bad = (rx_data_i[7:0] < {1'b0, ACD_BLK_MIN}) ||
		(rx_data_i[7:0] > {1'b0, ACD_BLK_MAX});
	assign crc_ok = ({rx_data_i, rx_lsb_reg} == rx_crc_reg);

	// Structural checks on a clean block; engine may still report 0x03 itself
	assign parse_bad = !dec_known || (rx_cnt_reg < dec_len_min) ||
		(rx_cnt_reg > dec_len_max);
	assign is_pause = (ibuf[ACD_IDX_OPCODE] == ACD_OP_PAUSE);
	assign pause_hit = (ibuf[ACD_IDX_PARAM1][3:0] == pause_sel_i);
	assign exec_timeout = (state_reg == ACD_EXEC) && !exec_done_i &&
		(exec_cnt_reg >= exec_limit_reg);

	// Which block, if any, to pack this cycle
	always_comb begin
		post_vld = 1'b0;
		post_res = 1'b0;
		post_code = ACD_ST_OK;
		go_exec = 1'b0;
		if (wake_i && !busy_o) begin
			post_vld = 1'b1;
			post_code = ACD_ST_WAKE;
		end else if (rx_first && count_bad) begin
			post_vld = 1'b1;
			post_code = ACD_ST_COMM_ERR;
		end else if (rx_last) begin
			if (!crc_ok) begin
				post_vld = 1'b1;
				post_code = ACD_ST_COMM_ERR;
			end else if (parse_bad) begin
				post_vld = 1'b1;
				post_code = ACD_ST_PARSE_ERR;
			end else if (is_pause) begin
				post_vld = !pause_hit;
				post_code = ACD_ST_OK;
			end else begin
				go_exec = 1'b1;
			end
		end else if (exec_timeout) begin
			post_vld = 1'b1;
			post_code = ACD_ST_EXEC_ERR;
		end else if ((state_reg == ACD_EXEC) && exec_done_i) begin
			post_vld = 1'b1;
			post_res = (exec_status_i == ACD_ST_OK) && (res_cnt_reg != 7'd0);
			post_code = exec_status_i;
		end
	end

	// Main sequence
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= ACD_IDLE;
		end else begin
			case (state_reg)
				ACD_IDLE: begin
					if (post_vld) begin
						state_reg <= ACD_SEAL;
					end else if (rx_first) begin
						state_reg <= ACD_RECV;
					end
				end
				ACD_RECV: begin
					if (post_vld) begin
						state_reg <= ACD_SEAL;
					end else if (go_exec) begin
						state_reg <= ACD_EXEC;
					end else if (rx_last) begin
						state_reg <= ACD_IDLE;
					end
				end
				ACD_EXEC: begin
					if (post_vld) begin
						state_reg <= ACD_SEAL;
					end
				end
				ACD_SEAL: begin
					if (seal_idx_reg == pkt_len_reg) begin
						state_reg <= ACD_IDLE;
					end
				end
				default: state_reg <= ACD_IDLE;
			endcase
		end
	end

	// Input capture and running checksum
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_idx_reg <= 7'd0;
			rx_cnt_reg <= 7'd0;
			rx_crc_reg <= ACD_CRC_INIT;
			rx_lsb_reg <= 8'h00;
		end else if (rx_take && !(wake_i && !busy_o)) begin
			ibuf[rx_idx_reg] <= rx_data_i;
			if (rx_first) begin
				rx_idx_reg <= 7'd1;
				rx_cnt_reg <= rx_data_i[6:0];
				rx_crc_reg <= rx_crc_next;
			end else begin
				rx_idx_reg <= rx_idx_reg + 7'd1;
				if (rx_idx_reg < rx_cnt_reg - 7'd2) begin
					rx_crc_reg <= rx_crc_next;
				end
				if (rx_idx_reg == rx_cnt_reg - 7'd2) begin
					rx_lsb_reg <= rx_data_i;
				end
			end
		end
	end

	// Engine may read any held byte; one-cycle latency
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cmd_byte_o <= 8'h00;
		end else begin
			cmd_byte_o <= ibuf[cmd_addr_i];
		end
	end

	// Command handed to the engine, latched at start
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			exec_opcode_o <= 8'h00;
			exec_param1_o <= 8'h00;
			exec_param2_o <= 16'h0000;
			exec_count_o <= 7'd0;
			exec_limit_reg <= 32'd0;
		end else if (go_exec) begin
			exec_opcode_o <= ibuf[ACD_IDX_OPCODE];
			exec_param1_o <= ibuf[ACD_IDX_PARAM1];
			exec_param2_o <= {ibuf[ACD_IDX_PARAM2_HI], ibuf[ACD_IDX_PARAM2_LO]};
			exec_count_o <= rx_cnt_reg;
			exec_limit_reg <= 32'(dec_max_ms) * 32'(CYCLES_PER_MS);
		end
	end

	// Execution time guard; a hung engine still yields an answer
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			exec_cnt_reg <= 32'd0;
		end else if (state_reg == ACD_EXEC) begin
			exec_cnt_reg <= exec_cnt_reg + 32'd1;
		end else begin
			exec_cnt_reg <= 32'd0;
		end
	end

	// Single-cycle strobes toward engine and link
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			exec_start_reg <= 1'b0;
			exec_abort_reg <= 1'b0;
			pause_idle_reg <= 1'b0;
		end else begin
			exec_start_reg <= go_exec;
			exec_abort_reg <= exec_timeout;
			// A wake on the last byte wins; the pause must not fire as well
			pause_idle_reg <= rx_last && !post_vld && crc_ok && !parse_bad && is_pause && pause_hit;
		end
	end
	assign exec_start_o = exec_start_reg;
	assign exec_abort_o = exec_abort_reg;
	assign pause_idle_o = pause_idle_reg;

	// Result byte count; extras past the block limit are dropped
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			res_cnt_reg <= 7'd0;
		end else if (go_exec) begin
			res_cnt_reg <= 7'd0;
		end else if ((state_reg == ACD_EXEC) && res_valid_i && (res_cnt_reg < ACD_MAX_PKT)) begin
			res_cnt_reg <= res_cnt_reg + 7'd1;
		end
	end

	// Sealing walk: count byte is supplied here before it is stored
	assign blk_len = pkt_len_reg + ACD_FRAME_OVH;
	assign seal_byte = (seal_idx_reg == 7'd0) ? {1'b0, blk_len} : obuf[seal_idx_reg];

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pkt_len_reg <= ACD_STAT_PKT;
			seal_idx_reg <= 7'd0;
			seal_crc_reg <= ACD_CRC_INIT;
		end else if (post_vld) begin
			pkt_len_reg <= post_res ? res_cnt_reg : ACD_STAT_PKT;
			seal_idx_reg <= 7'd0;
			seal_crc_reg <= ACD_CRC_INIT;
		end else if (state_reg == ACD_SEAL) begin
			seal_idx_reg <= seal_idx_reg + 7'd1;
			seal_crc_reg <= seal_crc_next;
		end
	end

	// Shared output buffer: status, error and result all land here
	always_ff @(posedge clk_i) begin
		if (post_vld && !post_res) begin
			obuf[ACD_IDX_OPCODE] <= post_code;
		end else if ((state_reg == ACD_EXEC) && res_valid_i && (res_cnt_reg < ACD_MAX_PKT)) begin
			obuf[res_cnt_reg + 7'd1] <= res_data_i;
		end else if ((state_reg == ACD_SEAL) && (seal_idx_reg == pkt_len_reg)) begin
			obuf[ACD_IDX_COUNT] <= {1'b0, blk_len};
			obuf[pkt_len_reg + 7'd1] <= seal_crc_next[7:0];
			obuf[pkt_len_reg + 7'd2] <= seal_crc_next[15:8];
		end
	end

	// Readable length; cleared while a block arrives or runs
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_len_reg <= 7'd0;
		end else if (rx_first || post_vld || go_exec) begin
			out_len_reg <= 7'd0;
		end else if ((state_reg == ACD_SEAL) && (seal_idx_reg == pkt_len_reg)) begin
			out_len_reg <= blk_len;
		end
	end

	// Read pointer; a fresh block always restarts at its count byte
	assign tx_avail_o = (state_reg == ACD_IDLE) && (out_ptr_reg < out_len_reg);
	assign out_ptr_next = (tx_rd_i && tx_avail_o) ? out_ptr_reg + 7'd1 : out_ptr_reg;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_ptr_reg <= 7'd0;
			tx_data_reg <= 8'h00;
		end else if (state_reg == ACD_SEAL) begin
			out_ptr_reg <= 7'd0;
			tx_data_reg <= {1'b0, blk_len};
		end else begin
			out_ptr_reg <= out_ptr_next;
			tx_data_reg <= obuf[out_ptr_next];
		end
	end
	assign tx_data_o = tx_data_reg;

endmodule

/* File: acd_pkg.sv */
package acd_pkg;

	// Clock figures
	localparam int ACD_CLK_HZ = 200_000_000;
	localparam int ACD_CLK_PERIOD_NS = 5;
	localparam int ACD_CYCLES_PER_MS = ACD_CLK_HZ / 1000;

	// Block framing (count byte, packet, two CRC bytes)
	localparam logic [6:0] ACD_BLK_MIN = 7'h04;
	localparam logic [6:0] ACD_BLK_MAX = 7'h54;
	localparam logic [6:0] ACD_CMD_MIN = 7'h07;
	localparam logic [6:0] ACD_FRAME_OVH = 7'h03;
	localparam logic [6:0] ACD_MAX_PKT = 7'h51;
	localparam logic [6:0] ACD_STAT_PKT = 7'h01;

	// Byte positions inside an input block
	localparam logic [6:0] ACD_IDX_COUNT = 7'h00;
	localparam logic [6:0] ACD_IDX_OPCODE = 7'h01;
	localparam logic [6:0] ACD_IDX_PARAM1 = 7'h02;
	localparam logic [6:0] ACD_IDX_PARAM2_LO = 7'h03;
	localparam logic [6:0] ACD_IDX_PARAM2_HI = 7'h04;

	// Status and error codes
	localparam logic [7:0] ACD_ST_OK = 8'h00;
	localparam logic [7:0] ACD_ST_MISCOMPARE = 8'h01;
	localparam logic [7:0] ACD_ST_PARSE_ERR = 8'h03;
	localparam logic [7:0] ACD_ST_EXEC_ERR = 8'h0f;
	localparam logic [7:0] ACD_ST_WAKE = 8'h11;
	localparam logic [7:0] ACD_ST_COMM_ERR = 8'hff;

	// Opcodes
	localparam logic [7:0] ACD_OP_KEY_DERIVATION = 8'h1c;
	localparam logic [7:0] ACD_OP_REVISION_QUERY = 8'h30;
	localparam logic [7:0] ACD_OP_DIGEST_GENERATION = 8'h15;
	localparam logic [7:0] ACD_OP_KEYED_HASH = 8'h11;
	localparam logic [7:0] ACD_OP_MAC_VERIFY = 8'h28;
	localparam logic [7:0] ACD_OP_ZONE_LOCK = 8'h17;
	localparam logic [7:0] ACD_OP_HASH_MAC = 8'h08;
	localparam logic [7:0] ACD_OP_NONCE = 8'h16;
	localparam logic [7:0] ACD_OP_PAUSE = 8'h01;
	localparam logic [7:0] ACD_OP_RANDOM = 8'h1b;
	localparam logic [7:0] ACD_OP_READ = 8'h02;
	localparam logic [7:0] ACD_OP_POST_LOCK_CONFIG_UPDATE = 8'h20;
	localparam logic [7:0] ACD_OP_WRITE = 8'h12;

	// Longest execution times, ms
	localparam logic [6:0] ACD_MS_KEY_DERIVATION = 7'd62;
	localparam logic [6:0] ACD_MS_REVISION_QUERY = 7'd2;
	localparam logic [6:0] ACD_MS_DIGEST_GENERATION = 7'd43;
	localparam logic [6:0] ACD_MS_KEYED_HASH = 7'd69;
	localparam logic [6:0] ACD_MS_MAC_VERIFY = 7'd38;
	localparam logic [6:0] ACD_MS_ZONE_LOCK = 7'd24;
	localparam logic [6:0] ACD_MS_HASH_MAC = 7'd35;
	localparam logic [6:0] ACD_MS_NONCE = 7'd60;
	localparam logic [6:0] ACD_MS_PAUSE = 7'd2;
	localparam logic [6:0] ACD_MS_RANDOM = 7'd50;
	localparam logic [6:0] ACD_MS_READ = 7'd4;
	localparam logic [6:0] ACD_MS_POST_LOCK_CONFIG_UPDATE = 7'd12;
	localparam logic [6:0] ACD_MS_WRITE = 7'd42;

	// Typical keyed-hash time the host waits before polling, ms
	localparam logic [6:0] ACD_TYP_MS_KEYED_HASH = 7'd27;

	// Block checksum
	localparam logic [15:0] ACD_CRC_POLY = 16'h8005;
	localparam logic [15:0] ACD_CRC_INIT = 16'h0000;

	typedef enum logic [1:0] {
		ACD_IDLE,
		ACD_RECV,
		ACD_EXEC,
		ACD_SEAL
	} acd_state_t;

endpackage

/* File: acd_crc16.sv */
`timescale 1ns/1ps
module acd_crc16
	import acd_pkg::*;
(
	// Running value and next byte
	input wire logic [15:0] crc_i,
	input wire logic [7:0] data_i,
	// Value after the byte
	output logic [15:0] crc_o
);

	// Bits enter least significant first
	always_comb begin
		logic [15:0] acc;
		acc = crc_i;
		for (int i = 0; i < 8; i++) begin
			if (acc[15] ^ data_i[i]) begin
				acc = {acc[14:0], 1'b0} ^ ACD_CRC_POLY;
			end else begin
				acc = {acc[14:0], 1'b0};
			end
		end
		crc_o = acc;
	end

endmodule

/* File: acd_opdec.sv */
`timescale 1ns/1ps
module acd_opdec
	import acd_pkg::*;
(
	// Opcode byte of the held block
	input wire logic [7:0] opcode_i,
	// Decode results
	output logic known_o,
	output logic [6:0] len_min_o,
	output logic [6:0] len_max_o,
	output logic [6:0] max_ms_o
);

	// Legal block lengths and time limits per opcode
	always_comb begin
		known_o = 1'b1;
		len_min_o = ACD_CMD_MIN;
		len_max_o = ACD_CMD_MIN;
		max_ms_o = ACD_MS_REVISION_QUERY;
		case (opcode_i)
			ACD_OP_KEY_DERIVATION: begin
				len_max_o = 7'd39;
				max_ms_o = ACD_MS_KEY_DERIVATION;
			end
			ACD_OP_DIGEST_GENERATION: begin
				len_max_o = 7'd11;
				max_ms_o = ACD_MS_DIGEST_GENERATION;
			end
			ACD_OP_KEYED_HASH: max_ms_o = ACD_MS_KEYED_HASH;
			ACD_OP_MAC_VERIFY: begin
				len_min_o = ACD_BLK_MAX;
				len_max_o = ACD_BLK_MAX;
				max_ms_o = ACD_MS_MAC_VERIFY;
			end
			ACD_OP_HASH_MAC: begin
				len_max_o = 7'd39;
				max_ms_o = ACD_MS_HASH_MAC;
			end
			ACD_OP_ZONE_LOCK: max_ms_o = ACD_MS_ZONE_LOCK;
			ACD_OP_NONCE: begin
				len_min_o = 7'd27;
				len_max_o = 7'd39;
				max_ms_o = ACD_MS_NONCE;
			end
			ACD_OP_RANDOM: max_ms_o = ACD_MS_RANDOM;
			ACD_OP_REVISION_QUERY: max_ms_o = ACD_MS_REVISION_QUERY;
			ACD_OP_READ: max_ms_o = ACD_MS_READ;
			ACD_OP_WRITE: begin
				len_min_o = 7'd11;
				len_max_o = 7'd71;
				max_ms_o = ACD_MS_WRITE;
			end
			ACD_OP_POST_LOCK_CONFIG_UPDATE: max_ms_o = ACD_MS_POST_LOCK_CONFIG_UPDATE;
			ACD_OP_PAUSE: max_ms_o = ACD_MS_PAUSE;
			default: known_o = 1'b0;
		endcase
	end

endmodule

/* File: acd_host_model.sv */
`timescale 1ns/1ps
module acd_host_model (
	// Clock
	input wire logic clk_i,
	// Link toward the device
	output logic wake_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic tx_rd_o,
	input wire logic rx_ready_i,
	input wire logic tx_avail_i,
	input wire logic [7:0] tx_data_i
);
	initial begin
		wake_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		tx_rd_o = 1'b0;
	end

	// Block checksum, data bits taken LSB first
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'h0000;
		foreach (b[i])
			for (int k = 0; k < 8; k++)
				c = {c[14:0], 1'b0} ^ ((b[i][k] ^ c[15]) ? 16'h8005 : 16'h0000);
		return c;
	endfunction

	task automatic step();
		@(posedge clk_i);
		#1;
	endtask

	task automatic wake();
		step();
		wake_o = 1'b1;
		step();
		wake_o = 1'b0;
	endtask

	// Whole block, count byte first; gap gives a slow host
	task automatic send(input logic [7:0] b[$], input int gap, output bit ok);
		int n;
		ok = 1'b1;
		step();
		foreach (b[i]) begin
			rx_valid_o = 1'b1;
			rx_data_o = b[i];
			n = 0;
			while (rx_ready_i !== 1'b1 && n < 2000) begin
				step();
				n++;
			end
			ok = ok && (n < 2000);
			step();
			// Released line shows junk, never the last byte
			if (gap > 0) begin
				rx_valid_o = 1'b0;
				rx_data_o = ~rx_data_o;
				repeat (gap) step();
			end
		end
		rx_valid_o = 1'b0;
		rx_data_o = ~rx_data_o;
	endtask

	// Polls until a block is readable, then takes count bytes
	task automatic read(output logic [7:0] q[$], output bit ok);
		int n;
		q = {};
		n = 0;
		while (tx_avail_i !== 1'b1 && n < 3000) begin
			step();
			n++;
		end
		ok = (n < 3000);
		if (ok) begin
			do begin
				q.push_back(tx_data_i);
				tx_rd_o = 1'b1;
				step();
			end while (q.size() < q[0] && q.size() < 84);
			tx_rd_o = 1'b0;
		end
	endtask
endmodule

/* File: acd_dispatch_chk.sv */
`timescale 1ns/1ps
module acd_dispatch_chk
	import acd_pkg::*;
#(
	parameter int CYCLES_PER_MS = ACD_CYCLES_PER_MS
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Link side
	input wire logic wake_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_ready_o,
	input wire logic tx_rd_i,
	input wire logic tx_avail_o,
	input wire logic [7:0] tx_data_o,
	input wire logic busy_o,
	input wire logic [3:0] pause_sel_i,
	input wire logic pause_idle_o,
	// Engine side
	input wire logic exec_start_o,
	input wire logic exec_abort_o,
	input wire logic [7:0] exec_opcode_o,
	input wire logic [7:0] exec_param1_o,
	input wire logic [15:0] exec_param2_o,
	input wire logic [6:0] exec_count_o,
	input wire logic [6:0] cmd_addr_i,
	input wire logic [7:0] cmd_byte_o,
	input wire logic res_valid_i,
	input wire logic [7:0] res_data_i,
	input wire logic exec_done_i,
	input wire logic [7:0] exec_status_i
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Link is shut while a command runs or a block is sealed
	a_busy_no_ready: assert property (busy_o |-> !rx_ready_o)
		else $error("byte accepted while busy");
	a_busy_no_read: assert property (busy_o |-> !tx_avail_o)
		else $error("output readable while busy");
	a_byte_hides: assert property (rx_valid_i && rx_ready_o |=> !tx_avail_o)
		else $error("output readable during input block");
	a_wake_block: assert property (wake_i && !busy_o |=> busy_o [*2] ##1 (tx_avail_o && tx_data_o == 8'h04))
		else $error("wake block late or wrong count");
	a_status_block: assert property (exec_done_i && busy_o && exec_status_i != ACD_ST_OK |-> ##3 (tx_avail_o && tx_data_o == 8'h04))
		else $error("status block missing after done");
	a_abort_block: assert property (exec_abort_o |-> ##[1:4] (tx_avail_o && tx_data_o == 8'h04))
		else $error("no block after time limit");
	// Buffer holds its byte until the host moves on
	a_avail_holds: assert property (tx_avail_o && !tx_rd_i && !wake_i && !rx_valid_i |=> tx_avail_o && $stable(tx_data_o))
		else $error("output block changed unread");
	a_pause_silent: assert property (pause_idle_o |-> !busy_o && !tx_avail_o)
		else $error("pause gave output or busy");
	a_start_busy: assert property (exec_start_o |-> busy_o && exec_opcode_o != ACD_OP_PAUSE)
		else $error("engine started while idle");

	c_start: cover property (exec_start_o);
	c_abort: cover property (exec_abort_o);
	c_pause: cover property (pause_idle_o);
	c_wake: cover property (wake_i && !busy_o);
endmodule

bind acd_dispatch acd_dispatch_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wake_i(wake_i), .rx_valid_i(rx_valid_i),
	.rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o), .tx_rd_i(tx_rd_i), .tx_avail_o(tx_avail_o),
	.tx_data_o(tx_data_o), .busy_o(busy_o), .pause_sel_i(pause_sel_i),
	.pause_idle_o(pause_idle_o), .exec_start_o(exec_start_o), .exec_abort_o(exec_abort_o),
	.exec_opcode_o(exec_opcode_o), .exec_param1_o(exec_param1_o),
	.exec_param2_o(exec_param2_o), .exec_count_o(exec_count_o), .cmd_addr_i(cmd_addr_i),
	.cmd_byte_o(cmd_byte_o), .res_valid_i(res_valid_i), .res_data_i(res_data_i),
	.exec_done_i(exec_done_i), .exec_status_i(exec_status_i)
);

/* File: acd_dispatch_tb.sv */
`timescale 1ns/1ps
module acd_dispatch_tb;
	import acd_pkg::*;
	typedef struct {logic [7:0] op; logic [7:0] cnt; logic [7:0] st; int nres; int run;} acd_row_t;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, wake_i, rx_valid_i, tx_rd_i, rx_ready_o, tx_avail_o;
	logic busy_o, pause_idle_o, exec_start_o, exec_abort_o, res_valid_i = 1'b0;
	logic exec_done_i = 1'b0;
	logic [7:0] rx_data_i, tx_data_o, exec_opcode_o, cmd_byte_o, res_data_i = 8'h00;
	logic [7:0] exec_param1_o;
	logic [15:0] exec_param2_o;
	logic [6:0] exec_count_o;
	bit ok;
	// Short limits keep the time-limit case fast
	localparam int SIM_CPM = 10;
	logic [7:0] exec_status_i = 8'h00;
	logic [7:0] b[$], q[$], e[$];
	int fails = 0, checks_done = 0, starts = 0, aborts = 0, pauses = 0, n0;
	int eng_wait = 0, eng_nres = 0, eng_mute = 0;
	logic [7:0] eng_st = 8'h00;
	// Opcode, count, engine code, result bytes, engine started
	acd_row_t rows[16] = '{'{8'h1c, 7, 8'h00, 32, 1}, '{8'h15, 11, 8'h00, 0, 1},
		'{8'h11, 7, 8'h00, 32, 1}, '{8'h28, 84, 8'h01, 0, 1}, '{8'h08, 39, 8'h00, 32, 1},
		'{8'h17, 7, 8'h0f, 0, 1}, '{8'h16, 27, 8'h00, 32, 1}, '{8'h1b, 7, 8'h00, 32, 1},
		'{8'h30, 7, 8'h00, 4, 1}, '{8'h02, 7, 8'h00, 4, 1}, '{8'h12, 71, 8'h03, 0, 1},
		'{8'h20, 7, 8'h00, 0, 1}, '{8'h30, 8, 8'h03, 0, 0}, '{8'h55, 7, 8'h03, 0, 0},
		'{8'h12, 72, 8'h03, 0, 0}, '{8'h28, 83, 8'h03, 0, 0}};

	acd_dispatch #(.CYCLES_PER_MS(SIM_CPM)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.wake_i(wake_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
		.rx_ready_o(rx_ready_o), .tx_rd_i(tx_rd_i), .tx_avail_o(tx_avail_o),
		.tx_data_o(tx_data_o), .busy_o(busy_o), .pause_sel_i(4'h5),
		.pause_idle_o(pause_idle_o), .exec_start_o(exec_start_o), .exec_abort_o(exec_abort_o),
		.exec_opcode_o(exec_opcode_o), .exec_param1_o(exec_param1_o),
		.exec_param2_o(exec_param2_o), .exec_count_o(exec_count_o),
		.cmd_addr_i(7'h01), .cmd_byte_o(cmd_byte_o), .res_valid_i(res_valid_i),
		.res_data_i(res_data_i), .exec_done_i(exec_done_i), .exec_status_i(exec_status_i));
	acd_host_model host (.clk_i(clk_i), .wake_o(wake_i), .rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i), .tx_rd_o(tx_rd_i), .rx_ready_i(rx_ready_o),
		.tx_avail_i(tx_avail_o), .tx_data_i(tx_data_o));

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic step();
		@(posedge clk_i);
		#1;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic need(input bit ok);
		if (!ok) begin
			fails++;
			test_done();
		end
	endtask

	// Command block with param2 0x5aa5 and data bytes zero
	task automatic mk_cmd(input logic [7:0] op, input logic [7:0] cnt, input logic [7:0] p1,
		input bit bad);
		logic [15:0] c;
		b = {cnt, op, p1, 8'ha5, 8'h5a};
		while (b.size() < cnt - 2) b.push_back(8'h00);
		c = host.crc16(b) ^ {15'h0000, bad};
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
	endtask

	// Sends b, reads the answer and compares it with the block the rules predict
	task automatic xfer(input int gap, input logic [7:0] code, input int nres);
		bit ok;
		host.send(b, gap, ok);
		need(ok);
		// Host holds off for the typical keyed-hash time before polling
		if (b.size() > 1 && b[1] == ACD_OP_KEYED_HASH) begin
			repeat (ACD_TYP_MS_KEYED_HASH * SIM_CPM) step();
		end
		host.read(q, ok);
		need(ok);
		cmp(code, nres);
	endtask

	// Compares q with a status block or a result block of nres bytes
	task automatic cmp(input logic [7:0] code, input int nres);
		logic [15:0] c;
		e = {8'h04, code};
		if (code == 8'h00 && nres > 0) begin
			e = {8'(nres + 3)};
			for (int i = 0; i < nres; i++) e.push_back(8'h40 + 8'(i));
		end
		c = host.crc16(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		check(q.size(), e.size());
		foreach (e[i]) check(q[i], e[i]);
	endtask

	// Engine stand-in; muted to provoke the time limit
	always begin
		step();
		if (exec_start_o === 1'b1) begin
			starts++;
			if (eng_mute == 0) begin
				repeat (eng_wait) step();
				for (int i = 0; i < eng_nres; i++) begin
					res_valid_i = 1'b1;
					res_data_i = 8'h40 + 8'(i);
					step();
				end
				res_valid_i = 1'b0;
				exec_done_i = 1'b1;
				exec_status_i = eng_st;
				step();
				exec_done_i = 1'b0;
			end
		end
	end

	always @(posedge clk_i) begin
		aborts <= aborts + int'(exec_abort_o === 1'b1);
		pauses <= pauses + int'(pause_idle_o === 1'b1);
	end

	initial begin
		repeat (100000) @(posedge clk_i);
		fails++;
		test_done();
	end

	initial begin
		repeat (16) @(posedge clk_i);
		check({busy_o, tx_avail_o, rx_ready_o}, 3'b001);
		#1 sys_rst_i = 1'b0;
		foreach (rows[i]) begin
			eng_wait = i;
			eng_nres = rows[i].nres;
			eng_st = rows[i].st;
			n0 = starts;
			mk_cmd(rows[i].op, rows[i].cnt, 8'(i), 1'b0);
			xfer(i % 2, rows[i].st, rows[i].nres);
			check(starts - n0, rows[i].run);
			if (rows[i].run == 1) begin
				check(cmd_byte_o, rows[i].op);
				check(exec_opcode_o, rows[i].op);
				check(exec_param1_o, 8'(i));
				check(exec_param2_o, 16'h5aa5);
				check(exec_count_o, rows[i].cnt);
			end
		end
		// Wake answer, then a wake while a command runs must not replace the result
		host.wake();
		host.read(q, ok);
		need(ok);
		cmp(8'h11, 0);
		eng_wait = 30;
		eng_nres = 32;
		eng_st = 8'h00;
		mk_cmd(8'h1b, 7, 8'h00, 1'b0);
		fork
			xfer(0, 8'h00, 32);
			begin
				// Lands well inside the engine's run, after the last byte
				repeat (12) step();
				host.wake();
			end
		join
		// Bad checksum outranks an unknown opcode; counts 0x03 and 0x55 are out of range and also give 0xff
		n0 = starts;
		mk_cmd(8'h55, 7, 8'h00, 1'b1);
		xfer(0, 8'hff, 0);
		b = {8'h03};
		xfer(0, 8'hff, 0);
		b = {8'h55};
		xfer(2, 8'hff, 0);
		check(starts - n0, 0);
		// Silent engine runs into the two-ms revision limit
		eng_mute = 1;
		n0 = aborts;
		mk_cmd(8'h30, 7, 8'h00, 1'b0);
		xfer(0, 8'h0f, 0);
		check(aborts - n0, 1);
		eng_mute = 0;
		// Pause: own selector idles quietly, another selector just succeeds
		n0 = pauses;
		mk_cmd(8'h01, 7, 8'h05, 1'b0);
		host.send(b, 0, ok);
		need(ok);
		repeat (4) step();
		check(pauses - n0, 1);
		check(tx_avail_o, 1'b0);
		mk_cmd(8'h01, 7, 8'h06, 1'b0);
		xfer(0, 8'h00, 0);
		test_done();
	end
endmodule
